// ===== dv/sfc_chk.sv
// Checker for sfc_top: sequencer phase lengths, mode entry, hop retune, register clamp.
// Assumes it is bound to sfc_top and sees only that module's ports.
`timescale 1ns/1ps
module sfc_chk
(
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [6:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic mode_tune_in,
	input wire logic mode_rx_in,
	input wire logic skip_cal_in,
	input wire logic pll_enable_out,
	input wire logic pll_locked_out,
	input wire logic rx_cleared_out,
	input wire logic [15:0] frac_word_out,
	input wire logic [2:0] state_out
);
	logic [2:0] prev_r;
	logic [12:0] cnt_r;
	// Counter holds the length of the previous state in the first cycle of a new one
	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			prev_r <= 3'h0;
			cnt_r <= 13'h0;
		end
		else
		begin
			prev_r <= state_out;
			cnt_r <= (state_out != prev_r) ? 13'h1 : cnt_r + 13'h1;
		end
	end
	default clocking dc @(posedge clk_in);
	endclocking
	default disable iff (!reset_n_in);
	idle_exit_a: assert property (state_out == 3'h0 && (mode_tune_in || mode_rx_in) &&
		!skip_cal_in |=> state_out == 3'h1) else $error("idle did not enter bias");
	skip_path_a: assert property (state_out == 3'h0 && (mode_tune_in || mode_rx_in) &&
		skip_cal_in |=> state_out == 3'h2) else $error("skip did not enter settle");
	idle_drop_a: assert property (!mode_tune_in && !mode_rx_in |=> state_out == 3'h0)
		else $error("no mode wanted but not idle");
	bias_len_a: assert property (state_out == 3'h3 && prev_r == 3'h1 |-> cnt_r == 13'h7d0)
		else $error("bias phase length wrong");
	cal_len_a: assert property (state_out == 3'h2 && prev_r == 3'h3 |-> cnt_r == 13'h7d0)
		else $error("calibration phase length wrong");
	settle_len_a: assert property ((state_out == 3'h4 || state_out == 3'h6) &&
		prev_r == 3'h2 |-> cnt_r == 13'hfa0) else $error("settle phase length wrong");
	hop_tune_a: assert property (state_out == 3'h6 && mode_rx_in && reg_wr_in &&
		(reg_addr_in == 7'h79 || reg_addr_in == 7'h7a) |=> state_out == 3'h4 && rx_cleared_out)
		else $error("hop write in receive did not return to tune");
	clear_pulse_a: assert property (rx_cleared_out |=> !rx_cleared_out)
		else $error("receive clear pulse too long");
	int_clamp_a: assert property (reg_wr_in && reg_addr_in == 7'h75 &&
		reg_wdata_in[4:0] > 5'h17 ##[1:2] reg_rd_in && reg_addr_in == 7'h75
		|=> reg_rdata_out[4:0] == 5'h17) else $error("integer field not clamped");
	frac_range_a: assert property (frac_word_out < 16'hfa00)
		else $error("fraction outside modulus");
	tune_lock_a: assert property (state_out == 3'h4 |-> pll_enable_out && pll_locked_out)
		else $error("loop not on and locked in tune");
endmodule

bind sfc_top sfc_chk sfc_chk_inst (.clk_in, .reset_n_in, .reg_wr_in, .reg_rd_in, .reg_addr_in,
	.reg_wdata_in, .reg_rdata_out, .mode_tune_in, .mode_rx_in, .skip_cal_in, .pll_enable_out,
	.pll_locked_out, .rx_cleared_out, .frac_word_out, .state_out);

// ===== dv/sfc_host.sv
// Host model: register writes and reads on the decoded access port.
// Assumes read data is registered and valid just after the read edge.
`timescale 1ns/1ps
module sfc_host
(
	input wire logic clk_in,
	input wire logic [7:0] rdata_in,
	output logic wr_out,
	output logic rd_out,
	output logic [6:0] addr_out,
	output logic [7:0] wdata_out
);
	initial
	begin
		wr_out = 1'b0;
		rd_out = 1'b0;
		addr_out = 7'h00;
		wdata_out = 8'h00;
	end
	// Released lines show the inverse so a stale value is never taken as live
	task automatic write_reg(input logic [6:0] a, input logic [7:0] d);
	begin
		@(posedge clk_in);
		wr_out <= 1'b1;
		addr_out <= a;
		wdata_out <= d;
		@(posedge clk_in);
		wr_out <= 1'b0;
		addr_out <= ~a;
		wdata_out <= ~d;
	end
	endtask
	task automatic read_reg(input logic [6:0] a, output logic [7:0] d);
	begin
		@(posedge clk_in);
		rd_out <= 1'b1;
		addr_out <= a;
		@(posedge clk_in);
		rd_out <= 1'b0;
		addr_out <= ~a;
		#1;
		d = rdata_in;
	end
	endtask
endmodule

// ===== dv/sfc_top_bench.sv
// Testbench for sfc_top: registers, frequency word, start-up sequence, hop retune.
// Assumes sfc_host drives the register port; the bench drives modes and AFC.
`timescale 1ns/1ps
module sfc_top_bench;
	logic clk_in, reset_n_in, reg_wr_in, reg_rd_in, mode_tune_in, mode_rx_in, skip_cal_in;
	logic afc_enable_in, mod_enable_in, mod_data_in, pll_enable_out, pll_locked_out;
	logic vco_cal_out, rx_enable_out, rx_cleared_out, band_high_out;
	logic [6:0] reg_addr_in, int_word_out;
	logic [7:0] reg_wdata_in, reg_rdata_out, deviation_field_in, divider_out, d;
	logic [9:0] afc_offset_in;
	logic [15:0] frac_word_out;
	logic [2:0] state_out;
	integer n_mismatch, total_checks, cycles;
	sfc_top sfc_top_inst (.clk_in, .reset_n_in, .reg_wr_in, .reg_rd_in, .reg_addr_in,
		.reg_wdata_in, .reg_rdata_out, .mode_tune_in, .mode_rx_in, .skip_cal_in, .afc_enable_in,
		.afc_offset_in, .mod_enable_in, .mod_data_in, .deviation_field_in, .pll_enable_out,
		.pll_locked_out, .vco_cal_out, .rx_enable_out, .rx_cleared_out, .band_high_out,
		.frac_word_out, .int_word_out, .divider_out, .state_out);
	sfc_host sfc_host_inst (.clk_in, .rdata_in(reg_rdata_out), .wr_out(reg_wr_in),
		.rd_out(reg_rd_in), .addr_out(reg_addr_in), .wdata_out(reg_wdata_in));
	initial
	begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end
	task automatic complete_run;
	begin
		if (n_mismatch == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	end
	endtask
	always @(posedge clk_in)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			n_mismatch++;
			complete_run;
		end
	end
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
	begin
		total_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	end
	endtask
	task automatic apply_reset;
	begin
		@(posedge clk_in);
		reset_n_in <= 1'b0;
		mode_tune_in <= 1'b0;
		mode_rx_in <= 1'b0;
		skip_cal_in <= 1'b0;
		afc_enable_in <= 1'b0;
		mod_enable_in <= 1'b0;
		repeat (8) @(posedge clk_in);
		reset_n_in <= 1'b1;
	end
	endtask
	// Word outputs are registered behind the register file, so allow two edges
	task automatic word_is(input logic [6:0] i, input logic [15:0] f);
	begin
		repeat (2) @(posedge clk_in);
		#1;
		chk("int word", {9'h0, i}, {9'h0, int_word_out});
		chk("frac word", f, frac_word_out);
	end
	endtask
	task automatic wait_state(input logic [2:0] s, input int lim);
	int i;
	begin
		i = 0;
		while (state_out !== s && i < lim)
		begin
			@(posedge clk_in);
			#1;
			i++;
		end
		chk("state", {13'h0, s}, {13'h0, state_out});
	end
	endtask
	task automatic t_regs;
	logic [6:0] a [8] = '{7'h73, 7'h74, 7'h75, 7'h76, 7'h77, 7'h79, 7'h7a, 7'h78};
	logic [7:0] r [8] = '{8'h00, 8'h00, 8'h35, 8'hbb, 8'h80, 8'h00, 8'h00, 8'h00};
	begin
		apply_reset;
		for (int k = 0; k < 8; k++)
		begin
			sfc_host_inst.read_reg(a[k], d);
			chk("reset value", {8'h0, r[k]}, {8'h0, d});
		end
		sfc_host_inst.write_reg(7'h75, 8'hff);
		sfc_host_inst.read_reg(7'h75, d);
		chk("band reg", 16'h0077, {8'h0, d});
		sfc_host_inst.write_reg(7'h74, 8'hff);
		sfc_host_inst.write_reg(7'h78, 8'h5a);
		sfc_host_inst.read_reg(7'h74, d);
		chk("offset high", 16'h0003, {8'h0, d});
		sfc_host_inst.read_reg(7'h78, d);
		chk("unmapped", 16'h0000, {8'h0, d});
	end
	endtask
	task automatic t_freq;
	begin
		apply_reset;
		word_is(7'h2d, 16'hbb80);
		sfc_host_inst.write_reg(7'h73, 8'hff);
		sfc_host_inst.write_reg(7'h74, 8'h03);
		word_is(7'h2d, 16'hbb7f);
		sfc_host_inst.write_reg(7'h7a, 8'h01);
		sfc_host_inst.write_reg(7'h79, 8'h02);
		word_is(7'h2d, 16'hbbbf);
		@(posedge clk_in);
		afc_enable_in <= 1'b1;
		afc_offset_in <= 10'h010;
		word_is(7'h2d, 16'hbbd0);
		sfc_host_inst.write_reg(7'h75, 8'h15);
		word_is(7'h2d, 16'hbc10);
		chk("band bit", 16'h0000, {15'h0, band_high_out});
		@(posedge clk_in);
		mod_enable_in <= 1'b1;
		mod_data_in <= 1'b0;
		deviation_field_in <= 8'h20;
		word_is(7'h2d, 16'hbbf0);
		sfc_host_inst.write_reg(7'h76, 8'hf9);
		sfc_host_inst.write_reg(7'h77, 8'hff);
		word_is(7'h2e, 16'h006f);
	end
	endtask
	// Positive deviation, then a half-way fraction whose mean the divider must follow
	task automatic t_modulator;
	int acc;
	int dv;
	begin
		@(posedge clk_in);
		mod_data_in <= 1'b1;
		word_is(7'h2e, 16'h00af);
		sfc_host_inst.write_reg(7'h76, 8'h7c);
		sfc_host_inst.write_reg(7'h77, 8'h50);
		word_is(7'h2d, 16'h7d00);
		acc = 0;
		repeat (16) @(posedge clk_in);
		// 64 ticks at one half should add about 128 over 256 clocks; ends allow slack
		for (int k = 0; k < 256; k++)
		begin
			@(posedge clk_in);
			#1;
			dv = int'(divider_out) - int'(int_word_out);
			if (dv < -3 || dv > 4)
				chk("divider step", 16'h0000, 16'(dv));
			acc += dv;
		end
		chk("divider mean", 16'h0001, {15'h0, (acc >= 96 && acc <= 160)});
	end
	endtask
	task automatic t_sequence;
	begin
		apply_reset;
		mode_tune_in <= 1'b1;
		wait_state(3'h3, 2100);
		chk("vco cal", 16'h0001, {15'h0, vco_cal_out});
		chk("pll enable", 16'h0001, {15'h0, pll_enable_out});
		wait_state(3'h4, 6100);
		word_is(7'h2d, 16'hbb80);
		@(posedge clk_in);
		mode_rx_in <= 1'b1;
		wait_state(3'h2, 4);
		wait_state(3'h6, 4100);
		chk("rx enable", 16'h0001, {15'h0, rx_enable_out});
		word_is(7'h2d, 16'hafc8);
		sfc_host_inst.write_reg(7'h7a, 8'h01);
		wait_state(3'h4, 3);
		repeat (20) @(posedge clk_in);
		#1;
		chk("tune held", 16'h0004, {13'h0, state_out});
		sfc_host_inst.write_reg(7'h79, 8'h02);
		wait_state(3'h1, 4);
		wait_state(3'h4, 8100);
		word_is(7'h2d, 16'hbbc0);
	end
	endtask
	task automatic t_skip;
	begin
		@(posedge clk_in);
		mode_tune_in <= 1'b0;
		mode_rx_in <= 1'b0;
		wait_state(3'h0, 3);
		chk("pll enable", 16'h0000, {15'h0, pll_enable_out});
		@(posedge clk_in);
		skip_cal_in <= 1'b1;
		mode_tune_in <= 1'b1;
		wait_state(3'h2, 3);
		wait_state(3'h4, 4100);
	end
	endtask
	initial
	begin
		n_mismatch = 0;
		total_checks = 0;
		cycles = 0;
		reset_n_in = 1'b0;
		mode_tune_in = 1'b0;
		mode_rx_in = 1'b0;
		skip_cal_in = 1'b0;
		afc_enable_in = 1'b0;
		afc_offset_in = 10'h000;
		mod_enable_in = 1'b0;
		mod_data_in = 1'b0;
		deviation_field_in = 8'h00;
		t_regs;
		t_freq;
		t_modulator;
		t_sequence;
		t_skip;
		complete_run;
	end
endmodule

// ===== rtl/sfc_dsm.sv
// Third-order MASH delta-sigma modulator with modulo 64000 accumulators.
// Assumes the fraction and integer inputs come from flops and tick_in marks the 10 MHz rate.
`timescale 1ns/1ps
`include "sfc_params.svh"
module sfc_dsm
	import sfc_pkg::*;
(
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic tick_in,
	input wire logic [15:0] frac_in,
	input wire logic [6:0] int_in,
	output logic [7:0] divider_out
);
	logic [15:0] acc1_r;
	logic [15:0] acc2_r;
	logic [15:0] acc3_r;
	logic c2_d_r;
	logic c3_d_r;
	logic c3_dd_r;
	logic [16:0] s1;
	logic [16:0] s2;
	logic [16:0] s3;
	logic [3:0] y;

	// Modulo add; bit 16 of the result is the carry
	function automatic logic [16:0] sfc_mod_add(input logic [15:0] a, input logic [15:0] b);
		logic [16:0] sum;
		sum = {1'b0, a} + {1'b0, b};
		if (sum >= `SFC_FRAC_MOD)
			sfc_mod_add = {1'b1, 16'(sum - `SFC_FRAC_MOD)};
		else
			sfc_mod_add = {1'b0, sum[15:0]};
	endfunction

	always_comb
	begin
		s1 = sfc_mod_add(acc1_r, frac_in);
		s2 = sfc_mod_add(acc2_r, s1[15:0]);
		s3 = sfc_mod_add(acc3_r, s2[15:0]);
		// Noise shaping: c1 + (1-z)c2 + (1-z)^2 c3, range -3 to +4
		y = 4'(s1[16]) + 4'(s2[16]) - 4'(c2_d_r) + 4'(s3[16])
			- 4'({c3_d_r, 1'b0}) + 4'(c3_dd_r);
	end

	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			acc1_r <= 16'h0000;
			acc2_r <= 16'h0000;
			acc3_r <= 16'h0000;
			c2_d_r <= 1'b0;
			c3_d_r <= 1'b0;
			c3_dd_r <= 1'b0;
		end
		else if (tick_in)
		begin
			acc1_r <= s1[15:0];
			acc2_r <= s2[15:0];
			acc3_r <= s3[15:0];
			c2_d_r <= s2[16];
			c3_d_r <= s3[16];
			c3_dd_r <= c3_d_r;
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			divider_out <= 8'h18;
		else if (tick_in)
			divider_out <= {1'b0, int_in} + {{4{y[3]}}, y};
	end
endmodule

// ===== rtl/sfc_params.svh
// Constants for the synthesizer frequency control block: offsets, fields, resets, timing.
// Assumes a 40 MHz system clock and a 10 MHz modulator rate derived from it.
`ifndef SFC_PARAMS_SVH
`define SFC_PARAMS_SVH

`define SFC_ADDR_OFFSET_LOW 7'h73
`define SFC_ADDR_OFFSET_HIGH 7'h74
`define SFC_ADDR_BAND_INT 7'h75
`define SFC_ADDR_CARRIER_HIGH 7'h76
`define SFC_ADDR_CARRIER_LOW 7'h77
`define SFC_ADDR_HOP_CHANNEL 7'h79
`define SFC_ADDR_HOP_STEP 7'h7a

`define SFC_RST_OFFSET_LOW 8'h00
`define SFC_RST_OFFSET_HIGH 8'h00
`define SFC_RST_BAND_INT 8'h35
`define SFC_RST_CARRIER_HIGH 8'hbb
`define SFC_RST_CARRIER_LOW 8'h80
`define SFC_RST_HOP_CHANNEL 8'h00
`define SFC_RST_HOP_STEP 8'h00

`define SFC_BIT_SIDE_BAND 6
`define SFC_BIT_HIGH_BAND 5
`define SFC_INT_FIELD_MAX 5'h17
`define SFC_INT_BASE 7'h18
`define SFC_OFFSET_HIGH_MASK 8'h03
`define SFC_BAND_INT_MASK 8'h7f

`define SFC_FRAC_MOD 17'h0fa00
`define SFC_RX_SHIFT_LOW 24'h001770
`define SFC_RX_SHIFT_HIGH 24'h000bb8
`define SFC_HOP_SHIFT_LOW 6
`define SFC_HOP_SHIFT_HIGH 5

`define SFC_CLK_MHZ 40
`define SFC_REF_DIV 4
`define SFC_BIAS_US 50
`define SFC_CAL_US 50
`define SFC_SETTLE_US 100
`define SFC_TOTAL_US 200
`define SFC_BIAS_CYC (`SFC_BIAS_US * `SFC_CLK_MHZ)
`define SFC_CAL_CYC (`SFC_CAL_US * `SFC_CLK_MHZ)
`define SFC_SETTLE_CYC (`SFC_SETTLE_US * `SFC_CLK_MHZ)

`endif

// ===== rtl/sfc_pkg.sv
// Types shared by the synthesizer frequency control block.
// Assumes sfc_params.svh is included by the files that need the constants.
package sfc_pkg;
	// Gray codes along idle, bias, calibration, settle, receive
	typedef enum logic [2:0]
	{
		SFC_IDLE = 3'h0,
		SFC_BIAS = 3'h1,
		SFC_CAL = 3'h3,
		SFC_SETTLE = 3'h2,
		SFC_RX = 3'h6,
		SFC_TUNE = 3'h4
	} sfc_state_t;
endpackage

// ===== rtl/sfc_top.sv
// Synthesizer frequency control: register file, frequency word, start-up sequencer.
// Assumes register accesses arrive already decoded from the serial interface, one per cycle.
//
// How it works
// - Calibrate the VCO on every frequency change and on every start from idle.
// - Time loop settling at 100 us; bias, calibration, settling fit in 200 us.
// - A skip input jumps over bias settling and calibration for faster turnaround.
// - Third-order modulator at 10 MHz with accumulators wrapping at 64000.
// - Carrier is 10 MHz times band factor times integer plus 24 plus fraction.
// - Integer divider field written above 23 is stored and read back as 23.
// - Band bit picks the divide-by-two outside the loop: 1 high, 0 low.
// - Fraction combines carrier word, offset word and deviation for in-loop modulation.
// - Receive lowers the synthesizer by 937.5 kHz for low-side injection.
// - Hop step times hop channel times 10 kHz is added to the nominal frequency.
// - Hop register write in receive returns to tune and retunes.
// - Manual offset word applies only with AFC off; AFC value replaces it.
// - Offset word is two's complement; host writes negatives as complements.
// - Each offset count moves the oscillator 156.25 Hz times band factor.
// - Host only sets the wanted mode; the sequencer performs every step.
// - Tune keeps the loop enabled and locked for fastest receive entry.
`timescale 1ns/1ps
`include "sfc_params.svh"
module sfc_top
	import sfc_pkg::*;
(
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [6:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	output logic [7:0] reg_rdata_out,
	input wire logic mode_tune_in,
	input wire logic mode_rx_in,
	input wire logic skip_cal_in,
	input wire logic afc_enable_in,
	input wire logic [9:0] afc_offset_in,
	input wire logic mod_enable_in,
	input wire logic mod_data_in,
	input wire logic [7:0] deviation_field_in,
	output logic pll_enable_out,
	output logic pll_locked_out,
	output logic vco_cal_out,
	output logic rx_enable_out,
	output logic rx_cleared_out,
	output logic band_high_out,
	output logic [15:0] frac_word_out,
	output logic [6:0] int_word_out,
	output logic [7:0] divider_out,
	output logic [2:0] state_out
);
	logic [7:0] offset_low_r;
	logic [7:0] offset_high_r;
	logic [7:0] band_int_r;
	logic [7:0] carrier_high_r;
	logic [7:0] carrier_low_r;
	logic [7:0] hop_channel_r;
	logic [7:0] hop_step_r;
	sfc_state_t state_r;
	sfc_state_t state_nxt;
	logic [11:0] timer_r;
	logic [11:0] timer_nxt;
	logic [23:0] tuned_word_r;
	logic hop_hold_r;
	logic [1:0] ref_cnt_r;
	logic ref_tick;
	logic hop_write;
	logic want_pll;
	logic want_rx;
	logic shift_on;
	logic seq_start;
	logic freq_changed;
	logic [4:0] integer_divider_field;
	logic [15:0] carrier_fraction_word;
	logic [9:0] offset_word;
	logic [15:0] hop_product;
	logic [23:0] hop_units;
	logic [23:0] offset_units;
	logic [23:0] shift_units;
	logic [23:0] dev_units;
	logic [23:0] static_word;
	logic [23:0] full_word;
	logic [22:0] split_word;

	// Integer part and modulo 64000 remainder of a word in fraction units
	function automatic logic [22:0] sfc_split(input logic [23:0] word);
		logic [23:0] rem;
		logic [6:0] quo;
		logic [23:0] den;
		rem = word;
		quo = 7'h00;
		for (int k = 6; k >= 0; k--)
		begin
			den = 24'(`SFC_FRAC_MOD) << k;
			if (rem >= den)
			begin
				rem = rem - den;
				quo[k] = 1'b1;
			end
		end
		sfc_split = {quo, rem[15:0]};
	endfunction

	// Stored value of the integer field, limited to the valid range
	function automatic logic [4:0] sfc_clamp_int(input logic [4:0] field);
		sfc_clamp_int = (field > `SFC_INT_FIELD_MAX) ? `SFC_INT_FIELD_MAX : field;
	endfunction

	assign hop_write = reg_wr_in && ((reg_addr_in == `SFC_ADDR_HOP_CHANNEL)
		|| (reg_addr_in == `SFC_ADDR_HOP_STEP));
	assign want_rx = mode_rx_in;
	assign want_pll = mode_rx_in || mode_tune_in;

	// Register file
	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			offset_low_r <= `SFC_RST_OFFSET_LOW;
			offset_high_r <= `SFC_RST_OFFSET_HIGH;
			band_int_r <= `SFC_RST_BAND_INT;
			carrier_high_r <= `SFC_RST_CARRIER_HIGH;
			carrier_low_r <= `SFC_RST_CARRIER_LOW;
			hop_channel_r <= `SFC_RST_HOP_CHANNEL;
			hop_step_r <= `SFC_RST_HOP_STEP;
		end
		else if (reg_wr_in)
		begin
			case (reg_addr_in)
				`SFC_ADDR_OFFSET_LOW: offset_low_r <= reg_wdata_in;
				`SFC_ADDR_OFFSET_HIGH: offset_high_r <= reg_wdata_in & `SFC_OFFSET_HIGH_MASK;
				`SFC_ADDR_BAND_INT:
					band_int_r <= {1'b0, reg_wdata_in[6:5], sfc_clamp_int(reg_wdata_in[4:0])};
				`SFC_ADDR_CARRIER_HIGH: carrier_high_r <= reg_wdata_in;
				`SFC_ADDR_CARRIER_LOW: carrier_low_r <= reg_wdata_in;
				`SFC_ADDR_HOP_CHANNEL: hop_channel_r <= reg_wdata_in;
				`SFC_ADDR_HOP_STEP: hop_step_r <= reg_wdata_in;
				default: ;
			endcase
		end
	end

	// Read data registered one cycle after the strobe; unmapped reads return zero
	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			reg_rdata_out <= 8'h00;
		else if (reg_rd_in)
		begin
			case (reg_addr_in)
				`SFC_ADDR_OFFSET_LOW: reg_rdata_out <= offset_low_r;
				`SFC_ADDR_OFFSET_HIGH: reg_rdata_out <= offset_high_r;
				`SFC_ADDR_BAND_INT: reg_rdata_out <= band_int_r & `SFC_BAND_INT_MASK;
				`SFC_ADDR_CARRIER_HIGH: reg_rdata_out <= carrier_high_r;
				`SFC_ADDR_CARRIER_LOW: reg_rdata_out <= carrier_low_r;
				`SFC_ADDR_HOP_CHANNEL: reg_rdata_out <= hop_channel_r;
				`SFC_ADDR_HOP_STEP: reg_rdata_out <= hop_step_r;
				default: reg_rdata_out <= 8'h00;
			endcase
		end
	end

	// Frequency word in units of 156.25 Hz times band factor
	always_comb
	begin
		integer_divider_field = band_int_r[4:0];
		carrier_fraction_word = {carrier_high_r, carrier_low_r};
		// Manual offset and AFC feed one offset word, so AFC overrides
		offset_word = afc_enable_in ? afc_offset_in : {offset_high_r[1:0], offset_low_r};
		// One offset count is exactly one fraction unit in either band
		offset_units = {{14{offset_word[9]}}, offset_word};
		hop_product = hop_step_r * hop_channel_r;
		// 10 kHz is 64 units in low band and 32 units in high band
		if (band_int_r[`SFC_BIT_HIGH_BAND])
			hop_units = {8'h00, hop_product} << `SFC_HOP_SHIFT_HIGH;
		else
			hop_units = {8'h00, hop_product} << `SFC_HOP_SHIFT_LOW;
		shift_units = 24'h000000;
		if (shift_on)
			shift_units = band_int_r[`SFC_BIT_HIGH_BAND] ? `SFC_RX_SHIFT_HIGH
				: `SFC_RX_SHIFT_LOW;
		// Modulation moves the fraction only, never the tuned word
		dev_units = 24'h000000;
		if (mod_enable_in)
			dev_units = mod_data_in ? {16'h0000, deviation_field_in}
				: 24'(-{16'h0000, deviation_field_in});
		static_word = 24'({1'b0, integer_divider_field} + `SFC_INT_BASE) * 24'(`SFC_FRAC_MOD)
			+ {8'h00, carrier_fraction_word} + offset_units + hop_units;
		full_word = static_word - shift_units + dev_units;
		split_word = sfc_split(full_word);
	end

	// Shift is applied while settling toward receive and during receive
	assign shift_on = want_rx && !hop_hold_r && ((state_r == SFC_SETTLE) || (state_r == SFC_RX));
	assign freq_changed = (static_word != tuned_word_r);

	// Sequencer
	always_comb
	begin
		state_nxt = state_r;
		seq_start = 1'b0;
		case (state_r)
			SFC_IDLE:
				if (want_pll)
				begin
					seq_start = 1'b1;
					state_nxt = skip_cal_in ? SFC_SETTLE : SFC_BIAS;
				end
			SFC_BIAS, SFC_CAL, SFC_SETTLE:
				if (!want_pll)
					state_nxt = SFC_IDLE;
				else if (freq_changed)
				begin
					seq_start = 1'b1;
					state_nxt = skip_cal_in ? SFC_SETTLE : SFC_BIAS;
				end
				else if (timer_r == 12'h000)
				begin
					if (state_r == SFC_BIAS)
						state_nxt = SFC_CAL;
					else if (state_r == SFC_CAL)
						state_nxt = SFC_SETTLE;
					else
						state_nxt = (want_rx && !hop_hold_r) ? SFC_RX : SFC_TUNE;
				end
			SFC_TUNE, SFC_RX:
				if (!want_pll)
					state_nxt = SFC_IDLE;
				else if (freq_changed)
				begin
					seq_start = 1'b1;
					state_nxt = skip_cal_in ? SFC_SETTLE : SFC_BIAS;
				end
				else if (state_r == SFC_RX && (hop_write || !want_rx))
					state_nxt = SFC_TUNE;
				else if (state_r == SFC_TUNE && want_rx && !hop_hold_r)
					state_nxt = SFC_SETTLE;
			default: state_nxt = SFC_IDLE;
		endcase
	end

	// Phase timer loaded on each phase entry with its length less one
	always_comb
	begin
		timer_nxt = (timer_r != 12'h000) ? timer_r - 12'h001 : 12'h000;
		if (state_nxt != state_r || seq_start)
		begin
			case (state_nxt)
				SFC_BIAS: timer_nxt = 12'(`SFC_BIAS_CYC - 1);
				SFC_CAL: timer_nxt = 12'(`SFC_CAL_CYC - 1);
				SFC_SETTLE: timer_nxt = 12'(`SFC_SETTLE_CYC - 1);
				default: timer_nxt = 12'h000;
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			state_r <= SFC_IDLE;
			timer_r <= 12'h000;
		end
		else
		begin
			state_r <= state_nxt;
			timer_r <= timer_nxt;
		end
	end

	// Word the loop was last calibrated for
	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			tuned_word_r <= 24'h000000;
		else if (seq_start)
			tuned_word_r <= static_word;
	end

	// Hop write in receive holds tune until the host drops its receive request;
	// a hop write made in receive wins over the release in the same cycle
	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			hop_hold_r <= 1'b0;
		else if (hop_write && state_r == SFC_RX)
			hop_hold_r <= 1'b1;
		else if (!want_rx)
			hop_hold_r <= 1'b0;
	end

	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			rx_cleared_out <= 1'b0;
		else
			rx_cleared_out <= hop_write && (state_r == SFC_RX);
	end

	// Modulator rate: one tick in four system clocks
	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			ref_cnt_r <= 2'h0;
		else
			ref_cnt_r <= ref_cnt_r + 2'h1;
	end
	assign ref_tick = (ref_cnt_r == 2'(`SFC_REF_DIV - 1));

	// Registered synthesizer controls
	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			int_word_out <= 7'h00;
			frac_word_out <= 16'h0000;
			band_high_out <= 1'b0;
			pll_enable_out <= 1'b0;
			pll_locked_out <= 1'b0;
			vco_cal_out <= 1'b0;
			rx_enable_out <= 1'b0;
		end
		else
		begin
			int_word_out <= split_word[22:16];
			frac_word_out <= split_word[15:0];
			band_high_out <= band_int_r[`SFC_BIT_HIGH_BAND];
			pll_enable_out <= (state_nxt != SFC_IDLE);
			pll_locked_out <= (state_nxt == SFC_TUNE) || (state_nxt == SFC_RX);
			vco_cal_out <= (state_nxt == SFC_CAL);
			rx_enable_out <= (state_nxt == SFC_RX);
		end
	end

	assign state_out = state_r;

	sfc_dsm u_dsm
	(
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.tick_in(ref_tick),
		.frac_in(frac_word_out),
		.int_in(int_word_out),
		.divider_out(divider_out)
	);
endmodule
